//--- include/gcsm_pkg.sv
// Notes on behaviour
// - Selected input below minimum swing: output freezes at last valid level.
// - Normal switch: follow current some pulses, hold low, then follow alternate.
// - Current stuck high: stay high some pulses, low some falls, follow.
// - Stretched cycle high and low phases exceed half the alternate period.
// - Current stuck low: stay low some alternate falls, then follow alternate.
// - Undetermined current: stuck-high or stuck-low path by last valid level.
// - Floating or dead selected clock: output stays at a stable level.
// - Select is asynchronous and synchronised; stage lengths may vary slightly.
// - Slowly degrading but toggling input need not be cleaned up.
// - Power-on reset puts switchover logic in a known state before use.
// - Both inputs handled identically; either may be the primary.
// - Guard strap off: plain multiplexer, switches immediately on select.
// - Guard on: switchover completes within seventeen cycles of select change.
package gcsm_pkg;
   localparam int          GCSM_NUM_INPUTS     = 2;
   localparam int          GCSM_SWITCH_LIMIT   = 17;
   localparam int          GCSM_MIN_STAGE      = 2;
   localparam int          GCSM_FOLLOW_PULSES  = 3;
   localparam int          GCSM_HIGH_PULSES    = 3;
   localparam int          GCSM_LOW_PULSES     = 3;
   localparam int          GCSM_CNT_WIDTH      = 5;
   localparam int          GCSM_STUCK_CYCLES   = 64;
   localparam int          GCSM_IDLE_WIDTH     = 12;
   localparam real         GCSM_POR_TIME_NS    = 1000.0;
   localparam real         GCSM_CLK_PERIOD_NS  = 10.0;
   localparam int          GCSM_POR_CYCLES     =
      int'($ceil(GCSM_POR_TIME_NS / GCSM_CLK_PERIOD_NS));
   localparam int          GCSM_POR_WIDTH      = 12;
   localparam logic        GCSM_OUT_RESET      = 1'b0;
   localparam logic        GCSM_SEL_RESET      = 1'b0;

   typedef enum logic [1:0] {
      GCSM_FOLLOW,
      GCSM_FINISH_CUR,
      GCSM_HOLD_HIGH,
      GCSM_HOLD_LOW
   } gcsm_state_type;
endpackage

//--- include/gcsm_track_if.sv
`timescale 1ns/100ps
interface gcsm_track_if;
   logic level;
   logic rise;
   logic fall;
   logic valid;
   logic lastValid;
   logic stuck;

   modport src (output level, rise, fall, valid, lastValid, stuck);
   modport dst (input  level, rise, fall, valid, lastValid, stuck);
endinterface

//--- src/gcsm_edge_tracker.sv
`timescale 1ns/100ps
module gcsm_edge_tracker
   import gcsm_pkg::*;
#(
   parameter int STUCK_CYCLES = GCSM_STUCK_CYCLES
) (
   input  wire logic    clk,       // System clock
   input  wire logic    rst_n,     // Synchronous reset, active low
   input  wire logic    clockPin,  // Raw clock input level
   input  wire logic    ampOkPin,  // Raw swing-above-minimum indication
   gcsm_track_if.src    trk        // Tracked view of this input
);
   // Refuse a stuck limit the idle counter cannot reach
   if (STUCK_CYCLES < 4 || STUCK_CYCLES >= (1 << GCSM_IDLE_WIDTH)) begin
      $error("STUCK_CYCLES out of range");
   end

   logic                       clkMeta_q;
   logic                       clkSync_q;
   logic                       clkPrev_q;
   logic                       ampMeta_q;
   logic                       ampSync_q;
   logic                       lastValid_q;
   logic [GCSM_IDLE_WIDTH-1:0] idle_q;
   logic [GCSM_IDLE_WIDTH-1:0] idleLimit;

   assign idleLimit = GCSM_IDLE_WIDTH'(STUCK_CYCLES);

   // Two flops before any use of the pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clkMeta_q <= 1'b0;
         clkSync_q <= 1'b0;
         clkPrev_q <= 1'b0;
      end else begin
         clkMeta_q <= clockPin;
         clkSync_q <= clkMeta_q;
         clkPrev_q <= clkSync_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ampMeta_q <= 1'b0;
         ampSync_q <= 1'b0;
      end else begin
         ampMeta_q <= ampOkPin;
         ampSync_q <= ampMeta_q;
      end
   end

   // Level captured only while the swing is adequate
   always_ff @(posedge clk) begin
      if (!rst_n)
         lastValid_q <= 1'b0;
      else if (ampSync_q)
         lastValid_q <= clkSync_q;
   end

   // Cycles since the last edge; saturates to flag a static input
   always_ff @(posedge clk) begin
      if (!rst_n)
         idle_q <= '0;
      else if (clkSync_q != clkPrev_q)
         idle_q <= '0;
      else if (idle_q != idleLimit)
         idle_q <= idle_q + 1'b1;
   end

   assign trk.level     = clkSync_q;
   assign trk.rise      = clkSync_q & ~clkPrev_q;
   assign trk.fall      = ~clkSync_q & clkPrev_q;
   assign trk.valid     = ampSync_q;
   assign trk.lastValid = lastValid_q;
   assign trk.stuck     = (idle_q == idleLimit);
endmodule

//--- src/gcsm_clock_mux.sv
`timescale 1ns/100ps
module gcsm_clock_mux
   import gcsm_pkg::*;
#(
   parameter int FOLLOW_PULSES = GCSM_FOLLOW_PULSES,
   parameter int HIGH_PULSES   = GCSM_HIGH_PULSES,
   parameter int LOW_PULSES    = GCSM_LOW_PULSES,
   parameter int STUCK_CYCLES  = GCSM_STUCK_CYCLES,
   parameter int POR_CYCLES    = GCSM_POR_CYCLES
) (
   input  wire logic clk,            // System clock, 100 MHz
   input  wire logic rst_n,          // Synchronous reset, active low
   input  wire logic clockInputZero, // Clock source 0
   input  wire logic clockInputOne,  // Clock source 1
   input  wire logic ampOkZero,      // Source 0 swing above minimum
   input  wire logic ampOkOne,       // Source 1 swing above minimum
   input  wire logic selectIn,       // Asynchronous select, 1 picks source 1
   input  wire logic runtPulseGuard, // Static strap, 1 enables guarded switch
   output logic      clockOut,       // Multiplexed clock, registered
   output logic      selectedInput,  // Source now driving the output
   output logic      switchBusy,     // Guarded switchover in progress
   output logic      porDone         // Power-on delay elapsed
);
   // Stage limits must leave room for synchroniser settling
   if (FOLLOW_PULSES < GCSM_MIN_STAGE || HIGH_PULSES < GCSM_MIN_STAGE ||
       LOW_PULSES < GCSM_MIN_STAGE) begin
      $error("Stage pulse counts below minimum");
   end
   if (FOLLOW_PULSES + HIGH_PULSES + LOW_PULSES > GCSM_SWITCH_LIMIT) begin
      $error("Stage pulse counts exceed switchover limit");
   end
   if (POR_CYCLES < 1 || POR_CYCLES >= (1 << GCSM_POR_WIDTH)) begin
      $error("POR_CYCLES out of range");
   end

   localparam logic [GCSM_CNT_WIDTH-1:0] FOLLOW_LAST =
      GCSM_CNT_WIDTH'(FOLLOW_PULSES - 1);
   localparam logic [GCSM_CNT_WIDTH-1:0] HIGH_LAST   =
      GCSM_CNT_WIDTH'(HIGH_PULSES - 1);
   localparam logic [GCSM_CNT_WIDTH-1:0] LOW_LAST    =
      GCSM_CNT_WIDTH'(LOW_PULSES - 1);
   localparam logic [GCSM_POR_WIDTH-1:0] POR_LAST    =
      GCSM_POR_WIDTH'(POR_CYCLES);

   logic [GCSM_NUM_INPUTS-1:0] pinClk;
   logic [GCSM_NUM_INPUTS-1:0] pinAmp;
   logic [GCSM_NUM_INPUTS-1:0] lvl;
   logic [GCSM_NUM_INPUTS-1:0] rise;
   logic [GCSM_NUM_INPUTS-1:0] fall;
   logic [GCSM_NUM_INPUTS-1:0] valid;
   logic [GCSM_NUM_INPUTS-1:0] lastValid;
   logic [GCSM_NUM_INPUTS-1:0] stuck;

   assign pinClk = {clockInputOne, clockInputZero};
   assign pinAmp = {ampOkOne, ampOkZero};

   gcsm_track_if trk [GCSM_NUM_INPUTS] ();

   // Identical tracking for each source
   for (genvar i = 0; i < GCSM_NUM_INPUTS; i++) begin : g_trk
      gcsm_edge_tracker #(
         .STUCK_CYCLES (STUCK_CYCLES)
      ) u_trk (
         .clk      (clk),
         .rst_n    (rst_n),
         .clockPin (pinClk[i]),
         .ampOkPin (pinAmp[i]),
         .trk      (trk[i])
      );
      assign lvl[i]       = trk[i].level;
      assign rise[i]      = trk[i].rise;
      assign fall[i]      = trk[i].fall;
      assign valid[i]     = trk[i].valid;
      assign lastValid[i] = trk[i].lastValid;
      assign stuck[i]     = trk[i].stuck;
   end

   logic                       selMeta_q;
   logic                       selSync_q;
   logic                       guardMeta_q;
   logic                       guardSync_q;
   logic [GCSM_POR_WIDTH-1:0]  por_q;
   gcsm_state_type             state_q;
   gcsm_state_type             state_d;
   logic                       cur_q;
   logic                       cur_d;
   logic [GCSM_CNT_WIDTH-1:0]  cnt_q;
   logic [GCSM_CNT_WIDTH-1:0]  cnt_d;
   logic                       out_q;
   logic                       out_d;
   logic                       alt;
   logic                       curFailed;
   logic                       curLastLevel;
   logic                       curSafeLevel;

   // Select and strap are asynchronous; two flops each
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         selMeta_q <= GCSM_SEL_RESET;
         selSync_q <= GCSM_SEL_RESET;
      end else begin
         selMeta_q <= selectIn;
         selSync_q <= selMeta_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         guardMeta_q <= 1'b0;
         guardSync_q <= 1'b0;
      end else begin
         guardMeta_q <= runtPulseGuard;
         guardSync_q <= guardMeta_q;
      end
   end

   // Power-on delay before the switch logic runs
   always_ff @(posedge clk) begin
      if (!rst_n)
         por_q <= '0;
      else if (por_q != POR_LAST)
         por_q <= por_q + 1'b1;
   end

   assign porDone = (por_q == POR_LAST);

   assign alt          = ~cur_q;
   assign curFailed    = stuck[cur_q] | ~valid[cur_q];
   // Decided level of a failed source: last valid one if swing was lost
   assign curLastLevel = valid[cur_q] ? lvl[cur_q] : lastValid[cur_q];
   // Fail-safe view; a degrading but toggling input passes through
   assign curSafeLevel = valid[cur_q] ? lvl[cur_q] : lastValid[cur_q];

   always_comb begin
      state_d = state_q;
      cur_d   = cur_q;
      cnt_d   = cnt_q;
      out_d   = out_q;
      case (state_q)
         GCSM_FOLLOW: begin
            out_d = curSafeLevel;
            if (!guardSync_q) begin
               cur_d = selSync_q;
               out_d = valid[selSync_q] ? lvl[selSync_q]
                                        : lastValid[selSync_q];
            end else if (selSync_q != cur_q) begin
               cnt_d = '0;
               if (curFailed && curLastLevel)
                  state_d = GCSM_HOLD_HIGH;
               else if (curFailed)
                  state_d = GCSM_HOLD_LOW;
               else
                  state_d = GCSM_FINISH_CUR;
            end
         end
         GCSM_FINISH_CUR: begin
            out_d = curSafeLevel;
            if (curFailed) begin
               cnt_d   = '0;
               state_d = curLastLevel ? GCSM_HOLD_HIGH : GCSM_HOLD_LOW;
            end else if (fall[cur_q]) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == FOLLOW_LAST) begin
                  cnt_d   = '0;
                  out_d   = 1'b0;
                  state_d = GCSM_HOLD_LOW;
               end
            end
         end
         GCSM_HOLD_HIGH: begin
            out_d = 1'b1;
            if (cnt_q == HIGH_LAST + 1'b1) begin
               // Drop only on an alternate fall: full high phase kept
               if (fall[alt]) begin
                  out_d   = 1'b0;
                  cnt_d   = '0;
                  state_d = GCSM_HOLD_LOW;
               end
            end else if (rise[alt]) begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         GCSM_HOLD_LOW: begin
            out_d = 1'b0;
            if (fall[alt]) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == LOW_LAST) begin
                  // Alternate is low here, so the hand-over is clean
                  cnt_d   = '0;
                  cur_d   = alt;
                  state_d = GCSM_FOLLOW;
               end
            end
         end
         default: begin
            state_d = GCSM_FOLLOW;
            cnt_d   = '0;
         end
      endcase
      if (!porDone) begin
         state_d = GCSM_FOLLOW;
         cnt_d   = '0;
         cur_d   = selSync_q;
         out_d   = GCSM_OUT_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= GCSM_FOLLOW;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         cur_q <= GCSM_SEL_RESET;
      else
         cur_q <= cur_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         out_q <= GCSM_OUT_RESET;
      else
         out_q <= out_d;
   end

   assign clockOut      = out_q;
   assign selectedInput = cur_q;
   assign switchBusy    = (state_q != GCSM_FOLLOW);
endmodule

//--- verification/gcsm_clock_mux_asserts.sv
`timescale 1ns/100ps
module gcsm_clock_mux_asserts (
   input wire logic clk,            // Clock
   input wire logic rst_n,          // Reset, active low
   input wire logic clockInputZero, // Source 0
   input wire logic clockInputOne,  // Source 1
   input wire logic ampOkZero,      // Swing ok 0
   input wire logic ampOkOne,       // Swing ok 1
   input wire logic selectIn,       // Select pin
   input wire logic runtPulseGuard, // Guard strap
   input wire logic clockOut,       // Output clock
   input wire logic selectedInput,  // Source in use
   input wire logic switchBusy,     // Switch running
   input wire logic porDone         // Power-on over
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_por_quiet: assert property (
      !porDone |-> !clockOut && !switchBusy)
      else $error("output active before power-on delay");
   a_busy_bound: assert property (
      $rose(switchBusy) |-> ##[1:600] !switchBusy)
      else $error("switchover did not finish");
   a_busy_cause: assert property (
      $rose(switchBusy) |-> runtPulseGuard && selectIn != selectedInput)
      else $error("switchover without guard or select change");
   a_sel_held: assert property (
      switchBusy |-> $stable(selectedInput))
      else $error("source changed during switchover");
   a_high_phase: assert property (
      runtPulseGuard && $past(runtPulseGuard, 4) && $rose(clockOut)
      |-> clockOut [*4])
      else $error("short high phase");
   a_low_phase: assert property (
      runtPulseGuard && $past(runtPulseGuard, 4) && porDone
      && $fell(clockOut) |-> !clockOut [*4])
      else $error("short low phase");
   a_fail_hold: assert property (
      (porDone && !switchBusy
       && !(selectedInput ? ampOkOne : ampOkZero)) [*4]
      |=> $stable(clockOut))
      else $error("output moved without swing");
   a_plain_select: assert property (
      !runtPulseGuard && !$past(runtPulseGuard, 4) && porDone
      && $changed(selectIn) |-> ##[1:4] selectedInput == selectIn)
      else $error("plain select too slow");
   a_plain_idle: assert property (
      !runtPulseGuard && !$past(runtPulseGuard, 4) |-> !switchBusy)
      else $error("switchover with guard off");

   c_to_one: cover property ($fell(switchBusy) && selectedInput);
   c_to_zero: cover property ($fell(switchBusy) && !selectedInput);
   c_hold: cover property (porDone && !ampOkZero && !selectedInput);
endmodule

//--- verification/gcsm_clock_src.sv
`timescale 1ns/100ps
module gcsm_clock_src #(
   parameter int HALF = 5
) (
   input wire logic clk,    // Bench clock
   input wire logic run,    // Keep toggling
   input wire logic stopAt, // Level to park at
   output logic     clkSrc  // Source clock
);
   int cnt = 0;

   initial clkSrc = 1'b0;
   // Halves of 5 and 6 cycles keep the two sources within 1.2:1
   always @(posedge clk) begin
      if (run || clkSrc != stopAt) begin
         if (cnt >= HALF - 1) begin
            cnt <= 0;
            clkSrc <= ~clkSrc;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

//--- verification/gcsm_clock_mux_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin \
   nMismatch++; $display("Error at %0t: got %h expected %h", \
   $time, (a), (e)); end end
module gcsm_clock_mux_tb;
   logic clk = 0, rst_n = 0, run0 = 0, run1 = 0, stop0 = 0, stop1 = 0;
   logic src0, src1, ampOkZero = 1, ampOkOne = 1, selectIn = 0;
   logic runtPulseGuard = 1, clockOut, selectedInput, switchBusy, porDone;
   int   nMismatch = 0, samplesChecked = 0;

   always #5 clk = ~clk;
   gcsm_clock_src #(.HALF(5)) i_gcsm_clock_src0 (.clk(clk), .run(run0),
      .stopAt(stop0), .clkSrc(src0));
   gcsm_clock_src #(.HALF(6)) i_gcsm_clock_src1 (.clk(clk), .run(run1),
      .stopAt(stop1), .clkSrc(src1));
   gcsm_clock_mux #(.STUCK_CYCLES(8), .POR_CYCLES(4)) i_gcsm_clock_mux (
      .clk(clk), .rst_n(rst_n), .clockInputZero(src0),
      .clockInputOne(src1), .ampOkZero(ampOkZero), .ampOkOne(ampOkOne),
      .selectIn(selectIn), .runtPulseGuard(runtPulseGuard),
      .clockOut(clockOut), .selectedInput(selectedInput),
      .switchBusy(switchBusy), .porDone(porDone));

   task stopTest;
      $display("Mismatches %0d, checks %0d", nMismatch, samplesChecked);
      if (nMismatch == 0 && samplesChecked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Output must carry the chosen source: equal rise counts, lag allowed
   task follows(input logic s);
      int ro, rs;
      logic po, ps;
      ro = 0;
      rs = 0;
      po = clockOut;
      ps = s ? src1 : src0;
      repeat (240) begin
         cyc(1);
         if (clockOut && !po) ro++;
         if ((s ? src1 : src0) && !ps) rs++;
         po = clockOut;
         ps = s ? src1 : src0;
      end
      `CHK(ro <= rs + 1 && rs <= ro + 1, 1'b1)
   endtask

   // Mode 1: current stuck high, mode 2: current stuck low
   task switchTo(input logic s, input int mode);
      int i;
      logic seenHigh;
      logic busyOut;
      seenHigh = 0;
      busyOut = 1'bx;
      @(posedge clk);
      selectIn <= s;
      for (i = 0; i < 1000 && switchBusy !== 1'b1; i++) cyc(1);
      `CHK(switchBusy, 1'b1)
      if (mode == 1) `CHK(clockOut, 1'b1)
      for (i = 0; i < 1000 && switchBusy !== 1'b0; i++) begin
         seenHigh |= clockOut;
         busyOut = clockOut;
         cyc(1);
      end
      `CHK(switchBusy, 1'b0)
      // Slowest source period is 12 bench clock cycles
      `CHK(i <= gcsm_pkg::GCSM_SWITCH_LIMIT * 12, 1'b1)
      `CHK(busyOut, 1'b0)
      `CHK(selectedInput, s)
      if (mode == 2) `CHK(seenHigh, 1'b0)
      follows(s);
   endtask

   task porCheck;
      int n;
      `CHK(porDone, 1'b0)
      `CHK(clockOut, 1'b0)
      for (n = 0; n < 20 && porDone !== 1'b1; n++) cyc(1);
      `CHK(n >= 3 && n <= 6, 1'b1)
   endtask

   task stuckCases;
      @(posedge clk);
      stop0 <= 1;
      run0 <= 0;
      cyc(30);
      switchTo(1, 1);
      run0 <= 1;
      stop1 <= 0;
      run1 <= 0;
      cyc(30);
      switchTo(0, 2);
      run1 <= 1;
   endtask

   task failSafe;
      logic v;
      @(posedge clk);
      ampOkZero <= 0;
      cyc(5);
      v = clockOut;
      cyc(30);
      `CHK(clockOut, v)
      switchTo(1, 0);
      @(posedge clk);
      ampOkZero <= 1;
   endtask

   task plainMux;
      @(posedge clk);
      runtPulseGuard <= 0;
      cyc(6);
      @(posedge clk);
      selectIn <= 0;
      cyc(5);
      `CHK(selectedInput, 1'b0)
      `CHK(switchBusy, 1'b0)
      follows(0);
   endtask

   initial begin
      @(posedge clk);
      #1;
      `CHK(porDone, 1'b0)
      `CHK(clockOut, 1'b0)
      `CHK(switchBusy, 1'b0)
      @(posedge clk);
      rst_n <= 1;
      cyc(1);
      porCheck();
      run0 <= 1;
      run1 <= 1;
      cyc(30);
      follows(0);
      switchTo(1, 0);
      switchTo(0, 0);
      stuckCases();
      failSafe();
      plainMux();
      stopTest();
   end

   initial begin
      #200us;
      nMismatch++;
      $display("Error at %0t: watchdog expired", $time);
      stopTest();
   end
endmodule

bind gcsm_clock_mux gcsm_clock_mux_asserts i_gcsm_clock_mux_asserts (
   .clk(clk), .rst_n(rst_n), .clockInputZero(clockInputZero),
   .clockInputOne(clockInputOne), .ampOkZero(ampOkZero),
   .ampOkOne(ampOkOne), .selectIn(selectIn),
   .runtPulseGuard(runtPulseGuard), .clockOut(clockOut),
   .selectedInput(selectedInput), .switchBusy(switchBusy),
   .porDone(porDone));
